// file: logic/stat_access_regs.vh
`ifndef STAT_ACCESS_REGS_VH
`define STAT_ACCESS_REGS_VH
// Register indices; byte address is four times the index
`define IDX_COUNTER_UPPER 16'h0430
`define IDX_COUNTER_MIDDLE 16'h0431
`define IDX_COUNTER_SELECT 16'h0432
`define IDX_MASTER_ENABLE 16'h0433
`define IDX_OVERFLOW_ENABLE 16'h0434
`define IDX_TRANSFER_CMD 16'h0440
`define IDX_IRQ_STATUS 16'h0441
`define IDX_IRQ_MASK 16'h0442
// Byte addresses
`define ADDR_COUNTER_UPPER 18'h010c0
`define ADDR_COUNTER_MIDDLE 18'h010c4
`define ADDR_COUNTER_SELECT 18'h010c8
`define ADDR_MASTER_ENABLE 18'h010cc
`define ADDR_OVERFLOW_ENABLE 18'h010d0
`define ADDR_TRANSFER_CMD 18'h01100
`define ADDR_IRQ_STATUS 18'h01104
`define ADDR_IRQ_MASK 18'h01108
// Fields
`define SEL_TYPE_MSB 8
`define SEL_TYPE_LSB 5
`define SEL_TARGET_MSB 4
`define SEL_TARGET_LSB 0
`define SEL_WRITABLE 16'h01ff
`define CMD_CLEAR_ALL 2'h0
`define CMD_VALUE 2'h1
`define CMD_IRQ_BIT 2'h2
`define CMD_DIR_BIT 2
`define RESET_MASTER_ENABLE 16'h0000
`define RESET_OVERFLOW_ENABLE 16'h0000
`define RESET_SELECT 16'h0000
`define CLEAR_LAST_IDX 10'h1ff
// Status bits
`define ST_XFER_DONE 0
`define ST_LINK_IRQ 1
`define ST_OVF_IRQ 2
`define NUM_LINKS 16
`define NUM_COUNTERS 12
`define NUM_GROUPS 8
`endif

// file: logic/stat_sync2.v
module stat_sync2 #(
  parameter WIDTH = 16
) (
  input wire core_clk_in,
  input wire sys_rst_in,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  always @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      stage1_reg <= {WIDTH{1'b0}};
      stage2_reg <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;
endmodule // stat_sync2

// file: logic/stat_counter_access.v
// Functional notes
// - After counter read, middle register holds byte 2 high, byte 1 low.
// - Middle register write is staged for later write transfer into bytes 2,1.
// - Staged data used for counter access only when transfer command issued.
// - Selector bits 15:9 always read as zero.
// - Types 1011..1000 select input cell-port all, idle, unassigned, HEC counters.
// - Types 0111..0100 select transmit total, idle, stuff, control counters.
// - Types 0011..0000 select receive total, idle, HEC, bad control counters.
// - Input-port types with target 10xxx select bundling group 0 to 7.
// - Target 0xxxx selects serial link 0 to 15.
// - Set enable bit plus set master interrupt bit drives interrupt pin low.
// - Cleared enable bit leaves pin unaffected by that link.
// - Overflow enable bit gates that link's overflow status onto interrupt.
// - Master enable register resets to all zeros.
// - Command 00 clears all, 01 accesses value, 10 accesses enable bit.
// - Upper staging register holds byte 3 in its low eight bits.
//
// Implementation choice: register access over APB.
`include "stat_access_regs.vh"

module stat_counter_access (
  input wire core_clk_in,
  input wire sys_rst_in,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [17:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [15:0] link_master_irq_in,
  input wire [15:0] link_overflow_status_in,
  output reg irq_n_out,
  output reg irq_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire [15:0] master_irq_sync;
  wire [15:0] overflow_sync;

  stat_sync2 #(.WIDTH(16)) master_sync_inst (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(link_master_irq_in),
    .sync_out(master_irq_sync)
  );

  stat_sync2 #(.WIDTH(16)) overflow_sync_inst (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(link_overflow_status_in),
    .sync_out(overflow_sync)
  );

  // ----------------------------------------------------------------
  // Registers and counter storage
  // ----------------------------------------------------------------
  reg [7:0] upper_stage_reg;
  reg [15:0] middle_stage_reg;
  reg [8:0] select_reg;
  reg [15:0] master_enable_reg;
  reg [15:0] overflow_enable_reg;
  reg [2:0] irq_status_reg;
  reg [2:0] irq_mask_reg;
  reg [2:0] cmd_last_reg;
  reg [23:0] counter_mem [0:511];
  reg irq_bit_mem [0:511];
  reg [9:0] clear_idx_reg;
  reg clr_state_reg;
  reg type_valid;
  reg [31:0] read_data_next;
  reg read_err_next;
  localparam CLR_IDLE = 1'b0;
  localparam CLR_RUN = 1'b1;
  reg prev_link_irq_reg;
  reg prev_ovf_irq_reg;
  integer i;

  wire access = psel & penable & pready;
  wire wr = access & pwrite;
  wire clearing = (clr_state_reg == CLR_RUN);
  wire status_clear = wr & (paddr == `ADDR_IRQ_STATUS);
  wire [3:0] sel_type = select_reg[`SEL_TYPE_MSB:`SEL_TYPE_LSB];
  wire [4:0] sel_target = select_reg[`SEL_TARGET_MSB:`SEL_TARGET_LSB];
  wire type_input_port = sel_type[3];
  // Index into storage: type and target together
  wire [8:0] sel_index = {sel_type, sel_target};
  // Group targets only meaningful for input-port types
  wire target_valid = type_valid & (sel_target[4] ? (type_input_port & ~sel_target[3])
    : 1'b1);

  // ----------------------------------------------------------------
  // Transfer command decode
  // ----------------------------------------------------------------
  wire cmd_write = wr & (paddr == `ADDR_TRANSFER_CMD);
  wire [1:0] cmd_code = pwdata[1:0];
  wire cmd_dir_write = pwdata[`CMD_DIR_BIT];

  // ----------------------------------------------------------------
  // Selector decode
  // ----------------------------------------------------------------
  always @*
  begin
    type_valid = 1'b0;
    case (sel_type)
      4'hb: type_valid = 1'b1;
      4'ha: type_valid = 1'b1;
      4'h9: type_valid = 1'b1;
      4'h8: type_valid = 1'b1;
      4'h7: type_valid = 1'b1;
      4'h6: type_valid = 1'b1;
      4'h5: type_valid = 1'b1;
      4'h4: type_valid = 1'b1;
      4'h3: type_valid = 1'b1;
      4'h2: type_valid = 1'b1;
      4'h1: type_valid = 1'b1;
      4'h0: type_valid = 1'b1;
      default: type_valid = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Interrupt combine
  // ----------------------------------------------------------------
  wire link_irq_any = |(master_enable_reg & master_irq_sync);
  wire ovf_irq_any = |(overflow_enable_reg & overflow_sync);
  wire [2:0] irq_events;

  assign irq_events[`ST_XFER_DONE] = cmd_write & (cmd_code != 2'h3);
  assign irq_events[`ST_LINK_IRQ] = link_irq_any & ~prev_link_irq_reg;
  assign irq_events[`ST_OVF_IRQ] = ovf_irq_any & ~prev_ovf_irq_reg;

  // ----------------------------------------------------------------
  // Register writes and transfers
  // ----------------------------------------------------------------
  always @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      upper_stage_reg <= 8'h00;
      middle_stage_reg <= 16'h0000;
      select_reg <= 9'h000;
      master_enable_reg <= `RESET_MASTER_ENABLE;
      overflow_enable_reg <= `RESET_OVERFLOW_ENABLE;
      irq_mask_reg <= 3'h0;
      cmd_last_reg <= 3'h0;
    end
    else
    begin
      if (wr)
      begin
        case (paddr)
          `ADDR_COUNTER_UPPER: upper_stage_reg <= pwdata[7:0];
          `ADDR_COUNTER_MIDDLE: middle_stage_reg <= pwdata[15:0];
          `ADDR_COUNTER_SELECT: select_reg <= pwdata[8:0];
          `ADDR_MASTER_ENABLE: master_enable_reg <= pwdata[15:0];
          `ADDR_OVERFLOW_ENABLE: overflow_enable_reg <= pwdata[15:0];
          `ADDR_IRQ_MASK: irq_mask_reg <= pwdata[2:0];
          default: ;
        endcase
      end
      // Staged bytes consumed only on a command
      if (cmd_write)
      begin
        cmd_last_reg <= pwdata[2:0];
        case (cmd_code)
          `CMD_CLEAR_ALL: ; // Clear sequencer does the work
          `CMD_VALUE:
          begin
            if (!cmd_dir_write && target_valid)
            begin
              upper_stage_reg <= counter_mem[sel_index][23:16];
              middle_stage_reg <= counter_mem[sel_index][15:0];
            end
          end
          `CMD_IRQ_BIT:
          begin
            if (!cmd_dir_write && target_valid)
            begin
              middle_stage_reg <= {15'h0000, irq_bit_mem[sel_index]};
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Storage has no reset: counter values cleared by command, interrupt bits are not
  always @(posedge core_clk_in)
  begin
    if (clearing)
    begin
      counter_mem[clear_idx_reg[8:0]] <= 24'h000000;
    end
    else if (cmd_write && cmd_dir_write && target_valid)
    begin
      if (cmd_code == `CMD_VALUE)
      begin
        counter_mem[sel_index] <= {upper_stage_reg, middle_stage_reg};
      end
      else if (cmd_code == `CMD_IRQ_BIT)
      begin
        irq_bit_mem[sel_index] <= middle_stage_reg[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and output
  // ----------------------------------------------------------------
  always @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      irq_status_reg <= 3'h0;
      prev_link_irq_reg <= 1'b0;
      prev_ovf_irq_reg <= 1'b0;
    end
    else
    begin
      prev_link_irq_reg <= link_irq_any;
      prev_ovf_irq_reg <= ovf_irq_any;
      // Set wins over write-one clear
      for (i = 0; i < 3; i = i + 1)
      begin
        if (irq_events[i])
        begin
          irq_status_reg[i] <= 1'b1;
        end
        else if (status_clear && pwdata[i])
        begin
          irq_status_reg[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pins
  // ----------------------------------------------------------------
  always @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      irq_n_out <= 1'b1;
      irq_out <= 1'b0;
    end
    else
    begin
      irq_n_out <= ~(link_irq_any | ovf_irq_any);
      irq_out <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Clear-all sequencer
  // ----------------------------------------------------------------
  always @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      clr_state_reg <= CLR_IDLE;
      clear_idx_reg <= 10'h000;
    end
    else
    begin
      case (clr_state_reg)
        CLR_IDLE:
        begin
          clear_idx_reg <= 10'h000;
          if (cmd_write && cmd_code == `CMD_CLEAR_ALL)
          begin
            clr_state_reg <= CLR_RUN;
          end
        end
        CLR_RUN:
        begin
          clear_idx_reg <= clear_idx_reg + 10'h001;
          if (clear_idx_reg == `CLEAR_LAST_IDX)
          begin
            clr_state_reg <= CLR_IDLE;
          end
        end
        default:
        begin
          clr_state_reg <= CLR_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data select
  // ----------------------------------------------------------------
  always @*
  begin
    read_data_next = 32'h00000000;
    read_err_next = 1'b0;
    case (paddr)
      `ADDR_COUNTER_UPPER: read_data_next = {24'h000000, upper_stage_reg};
      `ADDR_COUNTER_MIDDLE: read_data_next = {16'h0000, middle_stage_reg};
      `ADDR_COUNTER_SELECT: read_data_next = {23'h000000, select_reg};
      `ADDR_MASTER_ENABLE: read_data_next = {16'h0000, master_enable_reg};
      `ADDR_OVERFLOW_ENABLE: read_data_next = {16'h0000, overflow_enable_reg};
      `ADDR_TRANSFER_CMD: read_data_next = {29'h00000000, cmd_last_reg};
      `ADDR_IRQ_STATUS: read_data_next = {29'h00000000, irq_status_reg};
      `ADDR_IRQ_MASK: read_data_next = {29'h00000000, irq_mask_reg};
      default:
      begin
        read_data_next = 32'h00000000;
        read_err_next = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  always @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      // One wait state: ready in the second access cycle
      if (psel && penable && !pready)
      begin
        pready <= 1'b1;
        pslverr <= read_err_next;
        prdata <= read_data_next;
      end
      else
      begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

endmodule // stat_counter_access

// file: verification/stat_counter_access_chk.sv
`include "stat_access_regs.vh"
module stat_counter_access_chk (
  input wire core_clk_in,
  input wire sys_rst_in,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [17:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [15:0] link_master_irq_in,
  input wire [15:0] link_overflow_status_in,
  input wire irq_n_out
);
  wire any_src = |(link_master_irq_in | link_overflow_status_in);
  wire rd_done = pready && !pwrite;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_ready_wait: assert property (psel && penable && !pready |-> ##[0:2] pready)
    else $error("pready missing");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_zero: assert property (pslverr && rd_done |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_sel_unused: assert property (rd_done && paddr == `ADDR_COUNTER_SELECT |-> prdata[31:9] == 0)
    else $error("selector unused bits set");
  a_upper_byte: assert property (rd_done && paddr == `ADDR_COUNTER_UPPER |-> prdata[31:8] == 0)
    else $error("upper staging bits set");
  a_irq_cause: assert property ($fell(irq_n_out) |-> $past(any_src, 2))
    else $error("irq pin low without source");
  a_irq_quiet: assert property (!any_src [*4] |-> irq_n_out)
    else $error("irq pin low while idle");
endmodule // stat_counter_access_chk
bind stat_counter_access stat_counter_access_chk stat_counter_access_chk_inst (.core_clk_in,
  .sys_rst_in, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .link_master_irq_in, .link_overflow_status_in, .irq_n_out);

// file: verification/stat_counter_access_bench.sv
`include "stat_access_regs.vh"
module stat_counter_access_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in = 0, sys_rst_in = 1, psel = 0, penable = 0, pwrite = 0;
  logic [17:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, irq_n_out, irq_out, e;
  logic [15:0] link_master_irq_in = 0, link_overflow_status_in = 0;
  logic [8:0] sel [16];
  int mismatches = 0, tests_run = 0;
  always #5 core_clk_in = ~core_clk_in;
  stat_counter_access stat_counter_access_inst (.core_clk_in, .sys_rst_in, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link_master_irq_in,
    .link_overflow_status_in, .irq_n_out, .irq_out);
  // ----------------
  // Bus and compare
  // ----------------
  task chk(input [31:0] got, input [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task apb(input [17:0] a, input w, input [31:0] d);
    @(posedge core_clk_in);
    psel <= 1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge core_clk_in);
    penable <= 1;
    @(posedge core_clk_in);
    while (pready !== 1'b1) @(posedge core_clk_in);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input [17:0] a, input [31:0] d);
    apb(a, 1, d);
  endtask
  task rd(input [17:0] a, input [31:0] exp);
    apb(a, 0, 0);
    chk(r, exp);
  endtask
  task put(input [8:0] s, input [23:0] v);
    wr(`ADDR_COUNTER_SELECT, s);
    wr(`ADDR_COUNTER_UPPER, v[23:16]);
    wr(`ADDR_COUNTER_MIDDLE, v[15:0]);
    wr(`ADDR_TRANSFER_CMD, 32'h5);
  endtask
  task get(input [8:0] s, input [23:0] v);
    wr(`ADDR_COUNTER_UPPER, 32'hff);
    wr(`ADDR_COUNTER_MIDDLE, 32'hffff);
    wr(`ADDR_COUNTER_SELECT, s);
    wr(`ADDR_TRANSFER_CMD, 32'h1);
    rd(`ADDR_COUNTER_MIDDLE, v[15:0]);
    rd(`ADDR_COUNTER_UPPER, v[23:16]);
  endtask
  function automatic [23:0] val(input int i);
    return 24'h13579b ^ {3{i[7:0]}};
  endfunction
  // ----------------
  // Scenarios
  // ----------------
  task t_regs;
    rd(`ADDR_COUNTER_SELECT, 0);
    rd(`ADDR_MASTER_ENABLE, 0);
    rd(`ADDR_OVERFLOW_ENABLE, 0);
    wr(`ADDR_COUNTER_SELECT, 32'hffff);
    rd(`ADDR_COUNTER_SELECT, 32'h1ff);
    wr(`ADDR_MASTER_ENABLE, 32'ha5c3);
    rd(`ADDR_MASTER_ENABLE, 32'ha5c3);
    wr(`ADDR_OVERFLOW_ENABLE, 32'h3c5a);
    rd(`ADDR_OVERFLOW_ENABLE, 32'h3c5a);
    rd(18'h3fff0, 0);
    chk(e, 1);
    wr(`ADDR_MASTER_ENABLE, 0);
    wr(`ADDR_OVERFLOW_ENABLE, 0);
  endtask
  task t_counters;
    for (int i = 0; i < 16; i++) put(sel[i], val(i));
    for (int i = 0; i < 16; i++) get(sel[i], val(i));
    wr(`ADDR_TRANSFER_CMD, 32'h0);
    repeat (520) @(posedge core_clk_in);
    get(sel[3], 0);
    wr(`ADDR_COUNTER_MIDDLE, 32'h1);
    wr(`ADDR_TRANSFER_CMD, 32'h6);
    wr(`ADDR_COUNTER_MIDDLE, 32'h0);
    wr(`ADDR_TRANSFER_CMD, 32'h2);
    apb(`ADDR_COUNTER_MIDDLE, 0, 0);
    chk(r[0], 1);
  endtask
  task pin(input [15:0] m, input [15:0] o, input [15:0] me, input [15:0] oe, input x);
    link_master_irq_in <= m;
    link_overflow_status_in <= o;
    wr(`ADDR_MASTER_ENABLE, me);
    wr(`ADDR_OVERFLOW_ENABLE, oe);
    repeat (5) @(posedge core_clk_in);
    chk(irq_n_out, x);
  endtask
  task t_irq;
    pin(16'h0004, 0, 16'h0004, 0, 0);
    pin(16'h0004, 0, 16'hfffb, 0, 1);
    pin(0, 16'h0100, 0, 16'h0100, 0);
    pin(0, 16'h0100, 0, 16'hfeff, 1);
    pin(0, 0, 0, 0, 1);
    wr(`ADDR_IRQ_MASK, 0);
    wr(`ADDR_IRQ_STATUS, 32'h7);
    wr(`ADDR_TRANSFER_CMD, 32'h1);
    apb(`ADDR_IRQ_STATUS, 0, 0);
    chk(r[0], 1);
    chk(irq_out, 0);
    wr(`ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge core_clk_in);
    chk(irq_out, 1);
    wr(`ADDR_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge core_clk_in);
    chk(irq_out, 0);
  endtask
  task close_out;
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    for (int i = 0; i < 12; i++) sel[i] = {i[3:0], 5'h05};
    sel[12] = {4'hb, 5'h10};
    sel[13] = {4'hb, 5'h17};
    sel[14] = {4'h3, 5'h0f};
    sel[15] = {4'h0, 5'h00};
    repeat (2) @(posedge core_clk_in);
    sys_rst_in <= 0;
    t_regs;
    t_counters;
    t_irq;
    close_out;
  end
  initial
  begin
    repeat (20000) @(posedge core_clk_in);
    mismatches++;
    close_out;
  end
endmodule // stat_counter_access_bench
